/* File: rtl/adcsc_pkg.sv */
package adcsc_pkg;
  localparam int CLK_NS = 40;
  localparam int TCL_NS = 20;
  localparam int TCL_PER_CLK = CLK_NS / TCL_NS;
  localparam int CC_TCL_00 = 24;
  localparam int CC_TCL_10 = 96;
  localparam int CC_TCL_11 = 48;
  localparam int CONV_CC = 14;
  localparam int SAMP_SC = 2;
  localparam int XFER_TCL = 4;
  localparam int CALC_CC = 4;
  localparam int XFER_CYC = (XFER_TCL + TCL_PER_CLK - 1) / TCL_PER_CLK;
  localparam int CAL_NS = 1250000;
  localparam int CAL_CYC = (CAL_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAL_W = 16;
  localparam logic [CAL_W-1:0] CAL_CYC_DEF = CAL_W'(CAL_CYC);
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RES = 8'h04;
  localparam logic [7:0] OFF_INJ = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_DIN = 8'h14;
  localparam int CTRL_CH_LSB = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_RUN = 6;
  localparam int CTRL_BUSY = 7;
  localparam int CTRL_WFR = 8;
  localparam int CTRL_PROT = 9;
  localparam int CTRL_INJ = 10;
  localparam int CTRL_ICH_LSB = 12;
  localparam int CTRL_CTC_LSB = 16;
  localparam int CTRL_STC_LSB = 18;
  localparam int RES_CH_LSB = 12;
  localparam int ST_W = 3;
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
  localparam int ST_INJ = 2;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;
  typedef enum logic [1:0] {MODE_SINGLE, MODE_CONT, MODE_SCAN, MODE_SCAN_CONT} adcsc_mode_type;
  typedef struct packed {
    logic [3:0] mux;
    logic sample;
    logic convert;
    logic calib;
  } adcsc_afe_type;
  function automatic logic [11:0] cc_cycles(input logic [1:0] sel);
    case (sel)
      2'h2: cc_cycles = 12'(CC_TCL_10 / TCL_PER_CLK);
      2'h3: cc_cycles = 12'(CC_TCL_11 / TCL_PER_CLK);
      default: cc_cycles = 12'(CC_TCL_00 / TCL_PER_CLK);
    endcase
  endfunction : cc_cycles
endpackage : adcsc_pkg

/* File: rtl/adcsc_top.sv */
`timescale 1ns/100ps
`default_nettype none
module adcsc_top
  import adcsc_pkg::*;
#(
  parameter logic [CAL_W-1:0] CAL_CYCLES = CAL_CYC_DEF
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [9:0] i_conv_data,
  input wire logic [15:0] i_ain_dig,
  output var adcsc_afe_type o_afe,
  output logic o_busy,
  output logic o_eoc,
  output logic o_irq
);
  typedef enum logic [2:0] {S_IDLE, S_SAMPLE, S_CONVERT, S_XFER, S_CALC, S_HOLD} adcsc_state_type;

  logic [3:0] ch_reg;
  logic [3:0] ch_next;
  adcsc_mode_type mode_reg;
  adcsc_mode_type mode_next;
  logic run_reg;
  logic run_next;
  logic wfr_reg;
  logic wfr_next;
  logic prot_reg;
  logic prot_next;
  logic inj_req_reg;
  logic inj_req_next;
  logic [3:0] ich_reg;
  logic [3:0] ich_next;
  logic [1:0] ctc_reg;
  logic [1:0] ctc_next;
  logic [1:0] stc_reg;
  logic [1:0] stc_next;
  logic [9:0] res_reg;
  logic [9:0] res_next;
  logic [3:0] res_ch_reg;
  logic [3:0] res_ch_next;
  logic res_valid_reg;
  logic res_valid_next;
  logic [9:0] inj_res_reg;
  logic [9:0] inj_res_next;
  logic [3:0] inj_ch_reg;
  logic [3:0] inj_ch_next;
  logic [9:0] tmp_reg;
  logic [9:0] tmp_next;
  logic [3:0] tmp_ch_reg;
  logic [3:0] tmp_ch_next;
  logic [ST_W-1:0] stat_reg;
  logic [ST_W-1:0] stat_next;
  logic [ST_W-1:0] mask_reg;
  logic [ST_W-1:0] mask_next;
  logic [15:0] din_reg;
  logic [15:0] din_next;
  adcsc_state_type state_reg;
  adcsc_state_type state_next;
  logic [11:0] cnt_reg;
  logic [11:0] cnt_next;
  logic [3:0] ptr_reg;
  logic [3:0] ptr_next;
  logic is_inj_reg;
  logic is_inj_next;
  logic [CAL_W-1:0] cal_reg;
  logic [CAL_W-1:0] cal_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  adcsc_afe_type afe_reg;
  adcsc_afe_type afe_next;
  logic busy_reg;
  logic busy_next;
  logic eoc_reg;
  logic eoc_next;
  logic irq_reg;
  logic irq_next;

  logic acc;
  logic wr;
  logic rd_cap;
  logic res_read;
  logic stat_read;
  logic cont;
  logic scan;
  logic [11:0] cc;
  logic [11:0] samp_len;
  logic [11:0] conv_len;
  logic [11:0] calc_len;
  logic [31:0] rdv;
  logic hit;
  logic [ST_W-1:0] ev;
  logic adv;
  logic put;
  logic [9:0] put_val;
  logic [3:0] put_ch;

  assign acc = i_psel & i_penable & pready_reg;
  assign wr = acc & i_pwrite;
  assign rd_cap = i_psel & i_penable & ~pready_reg & ~i_pwrite;
  assign res_read = rd_cap & (i_paddr == OFF_RES);
  assign stat_read = rd_cap & (i_paddr == OFF_STAT);
  assign cont = (mode_reg == MODE_CONT) || (mode_reg == MODE_SCAN_CONT);
  assign scan = (mode_reg == MODE_SCAN) || (mode_reg == MODE_SCAN_CONT);
  assign cc = cc_cycles(ctc_reg);
  assign samp_len = 12'((cc << stc_reg) * SAMP_SC);
  assign conv_len = 12'(cc * CONV_CC);
  assign calc_len = 12'(cc * CALC_CC);

  always_comb begin
    ch_next = ch_reg;
    mode_next = mode_reg;
    run_next = run_reg;
    wfr_next = wfr_reg;
    prot_next = prot_reg;
    inj_req_next = inj_req_reg;
    ich_next = ich_reg;
    ctc_next = ctc_reg;
    stc_next = stc_reg;
    res_next = res_reg;
    res_ch_next = res_ch_reg;
    res_valid_next = res_valid_reg;
    inj_res_next = inj_res_reg;
    inj_ch_next = inj_ch_reg;
    tmp_next = tmp_reg;
    tmp_ch_next = tmp_ch_reg;
    stat_next = stat_reg;
    mask_next = mask_reg;
    state_next = state_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    is_inj_next = is_inj_reg;
    cal_next = cal_reg;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = i_psel & i_penable & ~pready_reg;
    din_next = i_ain_dig;
    eoc_next = 1'b0;
    ev = '0;
    adv = 1'b0;
    put = 1'b0;
    put_val = i_conv_data;
    put_ch = ptr_reg;
    rdv = 32'h0;
    hit = 1'b1;
    case (i_paddr)
      OFF_CTRL: begin
        rdv[CTRL_CH_LSB +: 4] = ch_reg;
        rdv[CTRL_MODE_LSB +: 2] = mode_reg;
        rdv[CTRL_RUN] = run_reg;
        rdv[CTRL_BUSY] = busy_reg;
        rdv[CTRL_WFR] = wfr_reg;
        rdv[CTRL_PROT] = prot_reg;
        rdv[CTRL_INJ] = inj_req_reg;
        rdv[CTRL_ICH_LSB +: 4] = ich_reg;
        rdv[CTRL_CTC_LSB +: 2] = ctc_reg;
        rdv[CTRL_STC_LSB +: 2] = stc_reg;
      end
      OFF_RES: begin
        rdv[9:0] = res_reg;
        rdv[RES_CH_LSB +: 4] = res_ch_reg;
      end
      OFF_INJ: begin
        rdv[9:0] = inj_res_reg;
        rdv[RES_CH_LSB +: 4] = inj_ch_reg;
      end
      OFF_STAT: begin
        rdv[ST_W-1:0] = stat_reg;
      end
      OFF_MASK: begin
        rdv[ST_W-1:0] = mask_reg;
      end
      OFF_DIN: begin
        rdv[15:0] = din_reg;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (pready_next) begin
      prdata_next = rdv;
      pslverr_next = ~hit;
    end
    if (!(run_reg && cont)) begin
      inj_req_next = 1'b0;
    end
    if (wr && (i_paddr == OFF_CTRL)) begin
      ch_next = i_pwdata[CTRL_CH_LSB +: 4];
      mode_next = adcsc_mode_type'(i_pwdata[CTRL_MODE_LSB +: 2]);
      run_next = i_pwdata[CTRL_RUN];
      wfr_next = i_pwdata[CTRL_WFR];
      prot_next = i_pwdata[CTRL_PROT];
      inj_req_next = i_pwdata[CTRL_INJ];
      ich_next = i_pwdata[CTRL_ICH_LSB +: 4];
      ctc_next = i_pwdata[CTRL_CTC_LSB +: 2];
      stc_next = i_pwdata[CTRL_STC_LSB +: 2];
      if (i_pwdata[CTRL_RUN] && !run_reg) begin
        ptr_next = i_pwdata[CTRL_CH_LSB +: 4];
      end
    end
    if (wr && (i_paddr == OFF_MASK)) begin
      mask_next = i_pwdata[ST_W-1:0];
    end
    if (res_read) begin
      res_valid_next = 1'b0;
    end
    if (stat_read) begin
      stat_next = '0;
    end
    case (state_reg)
      S_IDLE: begin
        if (inj_req_reg && run_reg && cont) begin
          inj_req_next = 1'b0;
          is_inj_next = 1'b1;
          state_next = S_SAMPLE;
          cnt_next = 12'(samp_len - 12'h001);
        end else if (run_reg && !(prot_reg && res_valid_reg && !res_read)) begin
          is_inj_next = 1'b0;
          state_next = S_SAMPLE;
          cnt_next = 12'(samp_len - 12'h001);
        end
      end
      S_SAMPLE: begin
        cnt_next = 12'(cnt_reg - 12'h001);
        if (cnt_reg == 12'h000) begin
          state_next = S_CONVERT;
          cnt_next = 12'(conv_len - 12'h001);
        end
      end
      S_CONVERT: begin
        cnt_next = 12'(cnt_reg - 12'h001);
        if (cnt_reg == 12'h000) begin
          state_next = S_XFER;
          cnt_next = 12'(XFER_CYC - 1);
        end
      end
      S_XFER: begin
        cnt_next = 12'(cnt_reg - 12'h001);
        if (cnt_reg == 12'h000) begin
          state_next = S_CALC;
          cnt_next = 12'(calc_len - 12'h001);
          if (is_inj_reg) begin
            inj_res_next = i_conv_data;
            inj_ch_next = ich_reg;
            ev[ST_INJ] = 1'b1;
          end else if (wfr_reg && cont && res_valid_reg && !res_read) begin
            tmp_next = i_conv_data;
            tmp_ch_next = ptr_reg;
            state_next = S_HOLD;
          end else begin
            put = 1'b1;
            adv = 1'b1;
          end
        end
      end
      S_HOLD: begin
        if (res_read) begin
          put = 1'b1;
          put_val = tmp_reg;
          put_ch = tmp_ch_reg;
          adv = 1'b1;
          state_next = S_CALC;
          cnt_next = 12'(calc_len - 12'h001);
        end
      end
      S_CALC: begin
        cnt_next = 12'(cnt_reg - 12'h001);
        if (cnt_reg == 12'h000) begin
          state_next = S_IDLE;
        end
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
    if (put) begin
      if (res_valid_reg && !res_read) begin
        ev[ST_OVR] = 1'b1;
      end
      res_next = put_val;
      res_ch_next = put_ch;
      res_valid_next = 1'b1;
      ev[ST_DONE] = 1'b1;
      eoc_next = 1'b1;
    end
    if (adv) begin
      if (scan) begin
        if (ptr_reg == 4'h0) begin
          ptr_next = ch_reg;
          run_next = run_next & cont;
        end else begin
          ptr_next = 4'(ptr_reg - 4'h1);
        end
      end else begin
        run_next = run_next & cont;
      end
    end
    if ((state_reg == S_IDLE) && (cal_reg != '0)) begin
      cal_next = CAL_W'(cal_reg - 1'b1);
    end
    stat_next = stat_next | ev;
    busy_next = (cal_next != '0) || (state_next != S_IDLE);
    irq_next = |(stat_next & mask_next);
    afe_next.mux = is_inj_next ? ich_next : ptr_next;
    afe_next.sample = (state_next == S_SAMPLE);
    afe_next.convert = (state_next == S_CONVERT);
    afe_next.calib = (state_next == S_CALC) || ((state_next == S_IDLE) && (cal_next != '0));
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ch_reg <= 4'h0;
      mode_reg <= MODE_SINGLE;
      run_reg <= 1'b0;
      wfr_reg <= 1'b0;
      prot_reg <= 1'b0;
      inj_req_reg <= 1'b0;
      ich_reg <= 4'h0;
      ctc_reg <= 2'h0;
      stc_reg <= 2'h0;
      res_reg <= 10'h000;
      res_ch_reg <= 4'h0;
      res_valid_reg <= 1'b0;
      inj_res_reg <= 10'h000;
      inj_ch_reg <= 4'h0;
      tmp_reg <= 10'h000;
      tmp_ch_reg <= 4'h0;
      stat_reg <= '0;
      mask_reg <= MASK_RST;
      din_reg <= 16'h0000;
      state_reg <= S_IDLE;
      cnt_reg <= 12'h000;
      ptr_reg <= 4'h0;
      is_inj_reg <= 1'b0;
      cal_reg <= CAL_CYCLES;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      afe_reg <= '0;
      busy_reg <= 1'b1;
      eoc_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ch_reg <= ch_next;
      mode_reg <= mode_next;
      run_reg <= run_next;
      wfr_reg <= wfr_next;
      prot_reg <= prot_next;
      inj_req_reg <= inj_req_next;
      ich_reg <= ich_next;
      ctc_reg <= ctc_next;
      stc_reg <= stc_next;
      res_reg <= res_next;
      res_ch_reg <= res_ch_next;
      res_valid_reg <= res_valid_next;
      inj_res_reg <= inj_res_next;
      inj_ch_reg <= inj_ch_next;
      tmp_reg <= tmp_next;
      tmp_ch_reg <= tmp_ch_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      din_reg <= din_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
      is_inj_reg <= is_inj_next;
      cal_reg <= cal_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      afe_reg <= afe_next;
      busy_reg <= busy_next;
      eoc_reg <= eoc_next;
      irq_reg <= irq_next;
    end
  end

  assign o_prdata = prdata_reg;
  assign o_pready = pready_reg;
  assign o_pslverr = pslverr_reg;
  assign o_afe = afe_reg;
  assign o_busy = busy_reg;
  assign o_eoc = eoc_reg;
  assign o_irq = irq_reg;

  // Helper counters measure conversion and calibration lengths.
  logic [11:0] tot_cnt;
  logic [11:0] calc_cnt;
  logic xfer_end;
  assign xfer_end = (state_reg == S_XFER) && (cnt_reg == 12'h000);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      tot_cnt <= 12'h000;
      calc_cnt <= 12'h000;
    end else begin
      tot_cnt <= (state_next inside {S_SAMPLE, S_CONVERT, S_XFER}) ? 12'(tot_cnt + 12'h001) : 12'h000;
      calc_cnt <= (state_reg == S_CALC) ? 12'(calc_cnt + 12'h001) : 12'h000;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  ovr_flag_a: assert property (xfer_end && !is_inj_reg && !(wfr_reg && cont) && res_valid_reg && !res_read
    |=> stat_reg[ST_OVR] && res_valid_reg)
    else $error("overrun not flagged");
  prot_hold_a: assert property ((state_reg == S_IDLE) && prot_reg && res_valid_reg && !res_read
    && !(inj_req_reg && run_reg && cont) |=> state_reg == S_IDLE)
    else $error("conversion started over unread result");
  single_stop_a: assert property (xfer_end && !is_inj_reg && (mode_reg == MODE_SINGLE)
    && !(wr && (i_paddr == OFF_CTRL)) |=> !run_reg ##1 res_valid_reg || $past(res_read))
    else $error("single mode did not stop");
  conv_fast_a: assert property (xfer_end && (ctc_reg == 2'h0) && (stc_reg == 2'h0)
    |-> tot_cnt == 12'h0c2)
    else $error("fast conversion length wrong");
  conv_slow_a: assert property (xfer_end && (ctc_reg == 2'h2) && (stc_reg == 2'h3)
    |-> tot_cnt == 12'h5a2)
    else $error("slow conversion length wrong");
  calc_len_a: assert property ((state_reg == S_CALC) && (cnt_reg == 12'h000) && (ctc_reg == 2'h3)
    |-> calc_cnt == 12'h05f)
    else $error("calibration cycle length wrong");
  busy_conv_a: assert property ((state_reg != S_IDLE) |-> o_busy)
    else $error("busy low during conversion");
  cal_busy_a: assert property ((cal_reg != '0) && (state_reg == S_IDLE) |-> o_busy)
    else $error("busy low during calibration");
  cal_pause_a: assert property ((state_reg != S_IDLE) && (cal_reg != '0) |=> $stable(cal_reg))
    else $error("calibration ran during conversion");
  inj_keep_a: assert property (xfer_end && is_inj_reg && !(wr && (i_paddr == OFF_CTRL))
    |=> $stable(ptr_reg) && run_reg && stat_reg[ST_INJ])
    else $error("injection disturbed continuous mode");
  wfr_hold_a: assert property ((state_reg == S_HOLD) && !res_read |=> (state_reg == S_HOLD) && !o_afe.sample)
    else $error("wait for read did not hold");

  inj_done_c: cover property (xfer_end && is_inj_reg);
  ovr_c: cover property (stat_reg[ST_OVR]);
  hold_c: cover property ((state_reg == S_HOLD) ##1 (state_reg == S_CALC));
  scan_wrap_c: cover property (xfer_end && scan && (ptr_reg == 4'h0));
endmodule : adcsc_top
`default_nettype wire

/* File: tb/adcsc_afe_model.sv */
`timescale 1ns/100ps
`default_nettype none
module adcsc_afe_model
  import adcsc_pkg::*;
#(
  parameter logic [15:0] DIG_LEVELS = 16'h5a3c
) (
  input wire logic i_mclk,
  input var adcsc_afe_type i_afe,
  output logic [9:0] o_conv_data,
  output logic [15:0] o_ain_dig
);
  logic [9:0] held = 10'h155;
  logic hold = 1'b0;
  // The value follows the selected input and stays put until calibration starts.
  always @(posedge i_mclk) begin
    if (i_afe.convert) begin
      held <= {i_afe.mux, 2'h2, i_afe.mux};
      hold <= 1'b1;
    end else begin
      if (i_afe.calib) begin
        hold <= 1'b0;
      end
      if (!hold) begin
        held <= ~held;
      end
    end
  end
  assign o_conv_data = held;
  // Pins read as fixed digital levels.
  assign o_ain_dig = DIG_LEVELS;
endmodule : adcsc_afe_model
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import adcsc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hit, perr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, busy, eoc, irq;
  logic [9:0] conv_data;
  logic [15:0] ain_dig;
  adcsc_afe_type afe;
  int error_cnt = 0, n_checks = 0, n_smp = 0, n_cnv = 0, n_cal = 0, s0, c0, l0, k;
  int rows[4][6] = '{'{3, 0, 0, 24, 168, 48}, '{15, 2, 3, 768, 672, 192},
    '{0, 3, 2, 192, 336, 96}, '{9, 0, 3, 192, 168, 48}};
  adcsc_top #(.CAL_CYCLES(16'h0032)) adcsc_top_i (.i_mclk(mclk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_conv_data(conv_data), .i_ain_dig(ain_dig),
    .o_afe(afe), .o_busy(busy), .o_eoc(eoc), .o_irq(irq));
  adcsc_afe_model adcsc_afe_model_i (.i_mclk(mclk), .i_afe(afe), .o_conv_data(conv_data),
    .o_ain_dig(ain_dig));
  initial begin
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    n_smp <= n_smp + int'(afe.sample);
    n_cnv <= n_cnv + int'(afe.convert);
    n_cal <= n_cal + int'(afe.calib);
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk
  task close_out;
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_eoc(input int lim);
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge mclk);
      hit = (eoc === 1'b1);
    end
  endtask : wait_eoc
  task wait_idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) begin
      @(posedge mclk);
    end
    chk(busy, 1'b0);
  endtask : wait_idle
  function automatic logic [31:0] ctl(logic [3:0] ch, logic [1:0] md, logic [1:0] ctc, logic [1:0] stc,
    logic prot, logic inj, logic [3:0] ich, logic run);
    return {12'h0, stc, ctc, ich, 1'b0, inj, prot, 1'b0, 1'b0, run, md, ch};
  endfunction : ctl
  function automatic logic [31:0] res(logic [3:0] ch);
    return {16'h0, ch, 2'h0, ch, 2'h2, ch};
  endfunction : res
  initial begin
    #1600000;
    error_cnt++;
    close_out();
  end
  initial begin
    repeat (4) @(posedge mclk);
    chk(busy, 1'b1);
    rst <= 1'b0;
    repeat (45) @(posedge mclk);
    chk(busy, 1'b1);
    wait_idle();
    apb(1'b0, OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[r]) begin
      s0 = n_smp;
      c0 = n_cnv;
      apb(1'b1, OFF_CTRL, ctl(rows[r][0], 2'h0, rows[r][1], rows[r][2], 0, 0, 0, 1));
      l0 = n_cal;
      wait_eoc(3000);
      chk(hit, 1'b1);
      chk(busy, 1'b1);
      wait_idle();
      chk(n_smp - s0, rows[r][3]);
      chk(n_cnv - c0, rows[r][4]);
      chk(n_cal - l0, rows[r][5]);
      chk(irq, 1'b0);
      apb(1'b0, OFF_RES, 0);
      chk(rd, res(rows[r][0]));
    end
    apb(1'b0, OFF_STAT, 0);
    apb(1'b1, OFF_MASK, 32'h2);
    for (k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CTRL, ctl(5, 0, 0, 0, 0, 0, 0, 1));
      wait_eoc(400);
      wait_idle();
    end
    chk(irq, 1'b1);
    apb(1'b0, OFF_STAT, 0);
    chk(rd, 32'h3);
    repeat (2) @(posedge mclk);
    chk(irq, 1'b0);
    apb(1'b0, OFF_RES, 0);
    chk(rd, res(5));
    apb(1'b1, OFF_MASK, 32'h4);
    apb(1'b1, OFF_CTRL, ctl(4, 1, 0, 0, 1, 0, 0, 1));
    wait_eoc(400);
    repeat (20) @(posedge mclk);
    apb(1'b1, OFF_CTRL, ctl(4, 1, 0, 0, 1, 1, 11, 1));
    for (k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge mclk);
    apb(1'b0, OFF_INJ, 0);
    chk(rd, res(11));
    wait_eoc(600);
    chk(hit, 1'b0);
    for (k = 0; k < 2; k++) begin
      apb(1'b0, OFF_RES, 0);
      chk(rd, res(4));
      wait_eoc(400);
      chk(hit, 1'b1);
    end
    apb(1'b1, OFF_CTRL, 0);
    wait_idle();
    apb(1'b0, OFF_RES, 0);
    apb(1'b1, OFF_CTRL, ctl(2, 2, 0, 0, 0, 0, 0, 1));
    for (k = 2; k >= 0; k--) begin
      wait_eoc(400);
      apb(1'b0, OFF_RES, 0);
      chk(rd, res(k));
    end
    wait_idle();
    apb(1'b0, OFF_CTRL, 0);
    chk(rd[CTRL_RUN], 1'b0);
    apb(1'b1, OFF_CTRL, ctl(1, 3, 0, 0, 0, 0, 0, 1));
    for (k = 0; k < 4; k++) begin
      wait_eoc(400);
      apb(1'b0, OFF_RES, 0);
      chk(rd, res(k % 2 == 0 ? 1 : 0));
    end
    apb(1'b1, OFF_CTRL, 0);
    wait_idle();
    apb(1'b0, OFF_RES, 0);
    apb(1'b0, OFF_STAT, 0);
    apb(1'b1, OFF_CTRL, ctl(6, 1, 0, 0, 0, 0, 0, 1) | (32'h1 << CTRL_WFR));
    wait_eoc(400);
    wait_eoc(600);
    chk({hit, busy}, 2'h1);
    apb(1'b0, OFF_RES, 0);
    chk(rd, res(6));
    apb(1'b1, OFF_CTRL, 0);
    apb(1'b0, OFF_STAT, 0);
    chk(rd, 32'h1);
    apb(1'b0, OFF_RES, 0);
    chk(rd, res(6));
    wait_idle();
    apb(1'b0, OFF_DIN, 0);
    chk(rd, 32'h5a3c);
    apb(1'b0, 8'h18, 0);
    chk(rd, 32'h0);
    chk(perr, 1'b1);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    apb(1'b1, OFF_CTRL, ctl(3, 0, 0, 0, 0, 0, 0, 1));
    for (k = 3; k < 3000 && busy !== 1'b0; k++) @(posedge mclk);
    chk(k >= 50 + 194 + 48, 1'b1);
    close_out();
  end
endmodule : tb
`default_nettype wire
